// >>> dtm_adc_link.sv
// adc-clock side of the raw sample link with toggle handshake to the core
// assumes the front end presents adc_vld with code and open flag per sample
`timescale 1ns/1ps
`default_nettype none
module dtm_adc_link (
	// clock and reset
	input  wire logic       adc_clk,
	input  wire logic       sys_rst,
	// front end
	input  wire logic       adc_vld,
	input  wire logic [7:0] adc_code,
	input  wire logic       adc_open,
	output logic            adc_run,
	output logic            adc_sel_remote,
	// core side
	input  wire logic       run_i,
	input  wire logic       sel_i,
	input  wire logic       ack_tgl,
	output logic            smp_tgl,
	output logic [7:0]      smp_code,
	output logic            smp_open,
	output logic            smp_sel
);
	logic       run_m, run_s, sel_m, sel_s, ack_m, ack_s;
	logic       req_q, req_d, open_q, open_d, tag_q, tag_d;
	logic [7:0] code_q, code_d;

	// one sample is held until the core toggles ack, so the data
	// lines are stable whenever the core sees the request toggle
	always_comb
	begin
		req_d  = req_q;
		code_d = code_q;
		open_d = open_q;
		tag_d  = tag_q;
		if (adc_vld && run_s && (req_q == ack_s))
		begin
			req_d  = ~req_q;
			code_d = adc_code;
			open_d = adc_open;
			tag_d  = sel_s;
		end
	end

	always_ff @(posedge adc_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			run_m  <= 1'b0;
			run_s  <= 1'b0;
			sel_m  <= 1'b0;
			sel_s  <= 1'b0;
			ack_m  <= 1'b0;
			ack_s  <= 1'b0;
			req_q  <= 1'b0;
			code_q <= 8'h00;
			open_q <= 1'b0;
			tag_q  <= 1'b0;
		end
		else
		begin
			run_m  <= run_i;
			run_s  <= run_m;
			sel_m  <= sel_i;
			sel_s  <= sel_m;
			ack_m  <= ack_tgl;
			ack_s  <= ack_m;
			req_q  <= req_d;
			code_q <= code_d;
			open_q <= open_d;
			tag_q  <= tag_d;
		end
	end

	assign adc_run        = run_s;
	assign adc_sel_remote = sel_s;
	assign smp_tgl        = req_q;
	assign smp_code       = code_q;
	assign smp_open       = open_q;
	assign smp_sel        = tag_q;
endmodule
`default_nettype wire

// >>> dtm_avg.sv
// sixteen-sample averaging filter for one conversion channel
// assumes samples arrive as single-cycle strobes on the core clock
`timescale 1ns/1ps
`default_nettype none
module dtm_avg
	import dtm_pkg::*;
#(
	parameter int LOG2 = DTM_AVG_LOG2
)(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// sample side
	input  wire logic       clr,
	input  wire logic       vld,
	input  wire logic [7:0] code,
	// result side
	output logic            done,
	output logic [7:0]      result
);
	logic signed [7+LOG2:0] sum_q, sum_d, sum_nx;
	logic [LOG2-1:0]        cnt_q, cnt_d;
	logic                   done_q, done_d;
	logic [7:0]             res_q, res_d;
	logic [7+LOG2:0]        avg_w;

	always_comb
	begin
		sum_d  = sum_q;
		cnt_d  = cnt_q;
		done_d = 1'b0;
		res_d  = res_q;
		sum_nx = sum_q + $signed({{LOG2{code[7]}}, code});
		avg_w  = sum_nx >>> LOG2;
		if (clr)
		begin
			sum_d = '0;
			cnt_d = '0;
		end
		else if (vld)
		begin
			if (cnt_q == '1)
			begin
				done_d = 1'b1;
				sum_d  = '0;
				cnt_d  = '0;
				// negative readings are outside the range, report 0
				res_d  = avg_w[7] ? DTM_TEMP_MIN : avg_w[7:0];
			end
			else
			begin
				sum_d = sum_nx;
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sum_q  <= '0;
			cnt_q  <= '0;
			done_q <= 1'b0;
			res_q  <= DTM_TEMP_MIN;
		end
		else
		begin
			sum_q  <= sum_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
			res_q  <= res_d;
		end
	end

	assign done   = done_q;
	assign result = res_q;

	AST_AVG_COUNT: assert property (@(posedge clk) disable iff (rst)
		done_q |-> $past(cnt_q) == '1 && $past(vld) && !$past(clr))
		else $error("average finished before sixteen samples");
endmodule
`default_nettype wire

// >>> dtm_core.sv
// dual-channel temperature monitor core: smbus slave, registers,
// conversion sequencer, limit flags and alert
// assumes the analog front end is clocked by adc_clk
`timescale 1ns/1ps
`default_nettype none
module dtm_core
	import dtm_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h18,
	// identification values are arbitrary
	parameter logic [7:0] MFG_ID   = 8'hA5,
	parameter logic [7:0] REV_ID   = 8'h5C
)(
	// clocks and reset
	input  wire logic       ref_clk,
	input  wire logic       adc_clk,
	input  wire logic       sys_rst,
	// smbus pins
	input  wire logic       smb_scl_i,
	input  wire logic       smb_sda_i,
	output logic            smb_sda_o,
	output logic            smb_sda_oe,
	// alert pin, open drain
	output logic            alert_n_o,
	output logic            alert_oe,
	// standby pin
	input  wire logic       standby_select_n,
	// analog front end
	input  wire logic       adc_vld,
	input  wire logic [7:0] adc_code,
	input  wire logic       adc_open,
	output logic            adc_run,
	output logic            adc_sel_remote
);
	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic stb_m, stb_s, tgl_m, tgl_s, tgl_d;
	logic [7:0] smp_code;
	logic smp_tgl, smp_open, smp_sel;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			stb_m <= 1'b1;
			stb_s <= 1'b1;
			tgl_m <= 1'b0;
			tgl_s <= 1'b0;
			tgl_d <= 1'b0;
		end
		else
		begin
			scl_m <= smb_scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= smb_sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
			stb_m <= standby_select_n;
			stb_s <= stb_m;
			tgl_m <= smp_tgl;
			tgl_s <= tgl_m;
			tgl_d <= tgl_s;
		end
	end

	logic rise_w, fall_w, start_w, stop_w;
	assign rise_w  = scl_s && !scl_d;
	assign fall_w  = !scl_s && scl_d;
	assign start_w = scl_s && scl_d && sda_d && !sda_s;
	assign stop_w  = scl_s && scl_d && !sda_d && sda_s;

	// ----------------------------------------------------------------
	// smbus slave
	// ----------------------------------------------------------------
	dtm_bus_e   bus_q, bus_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d, rd_data;
	logic [3:0] cnt_q, cnt_d;
	logic       rw_q, rw_d, first_q, first_d, oe_q, oe_d;
	logic       wr_en, st_clr, rd_go;

	always_comb
	begin
		bus_d   = bus_q;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		rw_d    = rw_q;
		first_d = first_q;
		ptr_d   = ptr_q;
		oe_d    = oe_q;
		wr_en   = 1'b0;
		st_clr  = 1'b0;
		rd_go   = 1'b0;
		if (stop_w)
		begin
			bus_d = DTM_BUS_IDLE;
			oe_d  = 1'b0;
		end
		else if (start_w)
		begin
			bus_d   = DTM_BUS_ADDR;
			cnt_d   = '0;
			first_d = 1'b1;
			oe_d    = 1'b0;
		end
		else
		begin
			unique case (bus_q)
				DTM_BUS_IDLE: ;
				DTM_BUS_ADDR, DTM_BUS_WR:
				begin
					if (rise_w)
					begin
						shift_d = {shift_q[6:0], sda_s};
						cnt_d   = cnt_q + 1'b1;
					end
					else if (fall_w && cnt_q == DTM_BYTE_BITS)
					begin
						cnt_d = '0;
						if (bus_q == DTM_BUS_WR)
						begin
							bus_d   = DTM_BUS_WACK;
							oe_d    = 1'b1;
							first_d = 1'b0;
							if (first_q)
								ptr_d = shift_q;
							else
								wr_en = 1'b1;
						end
						else if (shift_q[7:1] == DEV_ADDR)
						begin
							bus_d = DTM_BUS_AACK;
							oe_d  = 1'b1;
							rw_d  = shift_q[0];
						end
						else
							bus_d = DTM_BUS_IDLE;
					end
				end
				DTM_BUS_AACK:
				begin
					if (fall_w && rw_q)
						rd_go = 1'b1;
					else if (fall_w)
					begin
						oe_d  = 1'b0;
						bus_d = DTM_BUS_WR;
					end
				end
				DTM_BUS_WACK:
				begin
					if (fall_w)
					begin
						oe_d  = 1'b0;
						bus_d = DTM_BUS_WR;
					end
				end
				DTM_BUS_RD:
				begin
					if (rise_w)
						cnt_d = cnt_q + 1'b1;
					else if (fall_w && cnt_q == DTM_BYTE_BITS)
					begin
						oe_d  = 1'b0;
						bus_d = DTM_BUS_RACK;
					end
					else if (fall_w)
					begin
						shift_d = {shift_q[6:0], 1'b0};
						oe_d    = !shift_q[6];
					end
				end
				DTM_BUS_RACK:
				begin
					// a nack from the host ends the read
					if (rise_w && sda_s)
						bus_d = DTM_BUS_IDLE;
					else if (fall_w)
						rd_go = 1'b1;
				end
				default: bus_d = DTM_BUS_IDLE;
			endcase
		end
		if (rd_go)
		begin
			bus_d   = DTM_BUS_RD;
			shift_d = rd_data;
			oe_d    = !rd_data[7];
			cnt_d   = '0;
			st_clr  = (ptr_q == DTM_RA_STATUS);
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bus_q   <= DTM_BUS_IDLE;
			shift_q <= 8'h00;
			cnt_q   <= 4'h0;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			ptr_q   <= DTM_RST_PTR;
			oe_q    <= 1'b0;
		end
		else
		begin
			bus_q   <= bus_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
			rw_q    <= rw_d;
			first_q <= first_d;
			ptr_q   <= ptr_d;
			oe_q    <= oe_d;
		end
	end

	assign smb_sda_o  = 1'b0;
	assign smb_sda_oe = oe_q;

	// ----------------------------------------------------------------
	// registers, sequencer and flags
	// ----------------------------------------------------------------
	dtm_seq_e   seq_q, seq_d;
	logic [7:0] cfg_q, cfg_d, rate_q, rate_d, local_q, local_d, rem_q, rem_d;
	logic [7:0] lhi_q, lhi_d, llo_q, llo_d, rhi_q, rhi_d, rlo_q, rlo_d;
	logic [4:0] flags_q, flags_d, cond_w;
	logic       one_q, one_d, single_q, single_d, cmp_q, cmp_d;
	logic       openc_q, openc_d, opens_q, opens_d, ack_q, ack_d, alert_n_q, alert_n_d;
	logic       halt_w, new_w, take_w, avg_clr, avg_done;
	logic [7:0] avg_res;

	assign halt_w = cfg_q[DTM_CFG_HALT] || !stb_s;
	assign new_w  = tgl_s ^ tgl_d;
	assign take_w = new_w && ((seq_q == DTM_SEQ_LOCAL && !smp_sel)
		|| (seq_q == DTM_SEQ_REMOTE && smp_sel));

	// strict signed compares, per channel
	assign cond_w[DTM_F_LHI]  = $signed(local_q) > $signed(lhi_q);
	assign cond_w[DTM_F_LLO]  = $signed(local_q) < $signed(llo_q);
	assign cond_w[DTM_F_RHI]  = $signed(rem_q) > $signed(rhi_q);
	assign cond_w[DTM_F_RLO]  = $signed(rem_q) < $signed(rlo_q);
	assign cond_w[DTM_F_OPEN] = openc_q;

	always_comb
	begin
		unique case (ptr_q)
			DTM_RA_LOCAL:  rd_data = local_q;
			DTM_RA_REMOTE: rd_data = rem_q;
			DTM_RA_STATUS: rd_data = {seq_q != DTM_SEQ_IDLE, flags_q, DTM_ST_RSVD};
			DTM_RA_CFG:    rd_data = cfg_q;
			DTM_RA_RATE:   rd_data = rate_q;
			DTM_RA_LHI:    rd_data = lhi_q;
			DTM_RA_LLO:    rd_data = llo_q;
			DTM_RA_RHI:    rd_data = rhi_q;
			DTM_RA_RLO:    rd_data = rlo_q;
			DTM_RA_MFG:    rd_data = MFG_ID;
			DTM_RA_REV:    rd_data = REV_ID;
			default:       rd_data = DTM_INVALID;
		endcase
	end

	always_comb
	begin
		seq_d    = seq_q;
		cfg_d    = cfg_q;
		rate_d   = rate_q;
		lhi_d    = lhi_q;
		llo_d    = llo_q;
		rhi_d    = rhi_q;
		rlo_d    = rlo_q;
		local_d  = local_q;
		rem_d    = rem_q;
		one_d    = one_q;
		single_d = single_q;
		openc_d  = openc_q;
		opens_d  = opens_q || (take_w && seq_q == DTM_SEQ_REMOTE && smp_open);
		ack_d    = ack_q ^ new_w;
		// writes land only on write addresses; the rest are dropped
		if (wr_en)
		begin
			unique case (ptr_q)
				DTM_WA_CFG:     cfg_d  = shift_q & DTM_CFG_WMASK;
				DTM_WA_RATE:    rate_d = shift_q & DTM_RATE_MASK;
				DTM_WA_LHI:     lhi_d  = shift_q;
				DTM_WA_LLO:     llo_d  = shift_q;
				DTM_WA_RHI:     rhi_d  = shift_q;
				DTM_WA_RLO:     rlo_d  = shift_q;
				DTM_WA_ONESHOT: one_d  = 1'b1;
				default: ;
			endcase
		end
		unique case (seq_q)
			DTM_SEQ_IDLE:
			begin
				if (!halt_w || one_q)
				begin
					seq_d    = DTM_SEQ_LOCAL;
					single_d = halt_w;
					one_d    = 1'b0;
					opens_d  = 1'b0;
				end
			end
			DTM_SEQ_LOCAL:
			begin
				if (halt_w && !single_q)
					seq_d = DTM_SEQ_IDLE;
				else if (avg_done)
				begin
					local_d = avg_res;
					seq_d   = DTM_SEQ_REMOTE;
				end
			end
			DTM_SEQ_REMOTE:
			begin
				if (halt_w && !single_q)
					seq_d = DTM_SEQ_IDLE;
				else if (avg_done)
				begin
					rem_d    = avg_res;
					openc_d  = opens_q;
					single_d = 1'b0;
					seq_d    = DTM_SEQ_IDLE;
				end
			end
			default: seq_d = DTM_SEQ_IDLE;
		endcase
	end

	// comparison starts after the first full conversion, or at once
	// in standby so the reset values are judged
	assign cmp_d = cmp_q || halt_w || (seq_q == DTM_SEQ_REMOTE && avg_done && !halt_w)
		|| (seq_q == DTM_SEQ_REMOTE && avg_done && single_q);
	// set wins over the status-read clear
	assign flags_d = (st_clr ? (flags_q & cond_w) : flags_q) | (cmp_q ? cond_w : 5'h00);
	assign alert_n_d = !((|flags_q) && !cfg_q[DTM_CFG_MASK]);
	assign avg_clr = (seq_d != seq_q);

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seq_q     <= DTM_SEQ_IDLE;
			cfg_q     <= DTM_RST_CFG;
			rate_q    <= DTM_RST_RATE;
			lhi_q     <= DTM_RST_HI;
			llo_q     <= DTM_RST_LO;
			rhi_q     <= DTM_RST_HI;
			rlo_q     <= DTM_RST_LO;
			local_q   <= DTM_RST_TEMP;
			rem_q     <= DTM_RST_TEMP;
			flags_q   <= 5'h00;
			one_q     <= 1'b0;
			single_q  <= 1'b0;
			cmp_q     <= 1'b0;
			openc_q   <= 1'b0;
			opens_q   <= 1'b0;
			ack_q     <= 1'b0;
			alert_n_q <= 1'b1;
		end
		else
		begin
			seq_q     <= seq_d;
			cfg_q     <= cfg_d;
			rate_q    <= rate_d;
			lhi_q     <= lhi_d;
			llo_q     <= llo_d;
			rhi_q     <= rhi_d;
			rlo_q     <= rlo_d;
			local_q   <= local_d;
			rem_q     <= rem_d;
			flags_q   <= flags_d;
			one_q     <= one_d;
			single_q  <= single_d;
			cmp_q     <= cmp_d;
			openc_q   <= openc_d;
			opens_q   <= opens_d;
			ack_q     <= ack_d;
			alert_n_q <= alert_n_d;
		end
	end

	assign alert_n_o = alert_n_q;
	assign alert_oe  = !alert_n_q;

	dtm_avg #(.LOG2(DTM_AVG_LOG2)) u_avg (
		.clk    (ref_clk),
		.rst    (sys_rst),
		.clr    (avg_clr),
		.vld    (take_w && !avg_clr),
		.code   (smp_code),
		.done   (avg_done),
		.result (avg_res)
	);

	dtm_adc_link u_link (
		.adc_clk        (adc_clk),
		.sys_rst        (sys_rst),
		.adc_vld        (adc_vld),
		.adc_code       (adc_code),
		.adc_open       (adc_open),
		.adc_run        (adc_run),
		.adc_sel_remote (adc_sel_remote),
		.run_i          (seq_q != DTM_SEQ_IDLE),
		.sel_i          (seq_q == DTM_SEQ_REMOTE),
		.ack_tgl        (ack_q),
		.smp_tgl        (smp_tgl),
		.smp_code       (smp_code),
		.smp_open       (smp_open),
		.smp_sel        (smp_sel)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic       ever_q;
	logic [4:0] keep_w;
	assign keep_w = flags_q & cond_w;
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ever_q <= 1'b0;
		else if (seq_q == DTM_SEQ_REMOTE && avg_done)
			ever_q <= 1'b1;
	end

	AST_FREE_RUN: assert property (seq_q == DTM_SEQ_IDLE && !halt_w |=> seq_q == DTM_SEQ_LOCAL)
		else $error("conversion did not restart");
	AST_ALTERNATE: assert property (seq_q == DTM_SEQ_LOCAL && avg_done && !halt_w
		|=> seq_q == DTM_SEQ_REMOTE && local_q == $past(avg_res))
		else $error("remote channel did not follow local");
	AST_RESET_VAL: assert property (!ever_q && seq_q != DTM_SEQ_REMOTE
		|-> local_q == DTM_RST_TEMP && rem_q == DTM_RST_TEMP)
		else $error("value registers left reset code early");
	AST_RANGE: assert property (ever_q |-> !local_q[7] && !rem_q[7])
		else $error("reported value outside 0 to 127");
	AST_NO_EARLY_CMP: assert property (!cmp_q && flags_q == 5'h00 |=> flags_q == 5'h00)
		else $error("flag set before first comparison");
	AST_HALT_PWRUP: assert property (halt_w ##1 (halt_w && !ever_q && llo_q == DTM_RST_LO
		&& rlo_q == DTM_RST_LO && local_q == DTM_RST_TEMP && rem_q == DTM_RST_TEMP)
		|=> flags_q[DTM_F_LLO] && flags_q[DTM_F_RLO])
		else $error("standby start did not flag low limits");
	AST_HOLD: assert property (halt_w && seq_q == DTM_SEQ_IDLE && !one_q
		|=> $stable(local_q) && $stable(rem_q))
		else $error("values changed in standby");
	AST_CLR_HELD: assert property (st_clr |=> (flags_q & $past(keep_w)) == $past(keep_w))
		else $error("status read cleared an active flag");
	AST_ALERT: assert property ((|flags_q) && !cfg_q[DTM_CFG_MASK] |=> !alert_n_o && alert_oe)
		else $error("alert not asserted for set flag");
	AST_MASK: assert property (cfg_q[DTM_CFG_MASK] || flags_q == 5'h00 |=> alert_n_o)
		else $error("alert driven while masked or clear");
	AST_PTR: assert property (wr_en |-> ##1 ptr_q == $past(ptr_q) && !first_q)
		else $error("data byte moved the pointer");
	AST_WR_RO: assert property (wr_en && ptr_q == DTM_RA_LHI |=> $stable(lhi_q) && $stable(cfg_q))
		else $error("write to read address took effect");

	COV_CONV: cover property (seq_q == DTM_SEQ_REMOTE && avg_done);
	COV_CLR: cover property (st_clr && flags_q != 5'h00);
	COV_ONESHOT: cover property (one_q && halt_w ##1 seq_q == DTM_SEQ_LOCAL);
	COV_ALERT: cover property ($fell(alert_n_o));
endmodule
`default_nettype wire

// >>> dtm_host.sv
// smbus host model: bit-banged master with pointer, write and read tasks
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module dtm_host #(
	parameter logic [6:0] ADDR = 7'h18
)(
	// bus pins
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	localparam int Q = 50;
	logic [7:0] junk;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// ----------------------------------------------------------------
	// bit and byte level
	// ----------------------------------------------------------------
	// released data reads back through the pull-up, never a held value
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic start();
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#(4 * Q);
	endtask
	// the ninth bit is always released: ack on writes, nack ends a read
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, a);
	endtask
	// ----------------------------------------------------------------
	// transactions
	// ----------------------------------------------------------------
	task automatic set_ptr(input logic [7:0] p);
		start();
		xfer({ADDR, 1'b0}, junk);
		xfer(p, junk);
		stop();
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		xfer({ADDR, 1'b0}, junk);
		xfer(p, junk);
		xfer(d, junk);
		stop();
	endtask
	task automatic rd(output logic [7:0] d);
		start();
		xfer({ADDR, 1'b1}, junk);
		xfer(8'hFF, d);
		stop();
	endtask
endmodule
`default_nettype wire

// >>> dtm_pkg.sv
// constants, states and field layout of the temperature monitor core
// assumes a ref_clk core with an smbus slave and an adc link on adc_clk
// Functional notes
// - free-running conversions unless in standby
// - alternate local and remote channel each cycle
// - results stored as 8-bit twos complement
// - four limit registers, compare per channel
// - out-of-limit sets status flag, pulls alert low
// - limits/config writable, every register readable
// - value registers reset to minus 128
// - converting start: measure both before comparing
// - standby start: compare reset values, low flags
// - result averages sixteen raw measurements
// - one lsb per degree, range 0 to 127
// - revision upper nibble identifies part
// - pointer undefined at reset, host loads it
// - mask bit hides current and future alerts
// - separate read and write addresses
// - status read clears only resolved flags
// - first write byte loads the pointer
// - standby stops conversions, holds values
package dtm_pkg;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] DTM_RA_LOCAL   = 8'h00;
	localparam logic [7:0] DTM_RA_REMOTE  = 8'h01;
	localparam logic [7:0] DTM_RA_STATUS  = 8'h02;
	localparam logic [7:0] DTM_RA_CFG     = 8'h03;
	localparam logic [7:0] DTM_RA_RATE    = 8'h04;
	localparam logic [7:0] DTM_RA_LHI     = 8'h05;
	localparam logic [7:0] DTM_RA_LLO     = 8'h06;
	localparam logic [7:0] DTM_RA_RHI     = 8'h07;
	localparam logic [7:0] DTM_RA_RLO     = 8'h08;
	localparam logic [7:0] DTM_WA_CFG     = 8'h09;
	localparam logic [7:0] DTM_WA_RATE    = 8'h0A;
	localparam logic [7:0] DTM_WA_LHI     = 8'h0B;
	localparam logic [7:0] DTM_WA_LLO     = 8'h0C;
	localparam logic [7:0] DTM_WA_RHI     = 8'h0D;
	localparam logic [7:0] DTM_WA_RLO     = 8'h0E;
	localparam logic [7:0] DTM_WA_ONESHOT = 8'h0F;
	localparam logic [7:0] DTM_RA_MFG     = 8'hFE;
	localparam logic [7:0] DTM_RA_REV     = 8'hFF;
	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] DTM_RST_TEMP  = 8'h80;
	localparam logic [7:0] DTM_RST_CFG   = 8'h00;
	localparam logic [7:0] DTM_RST_RATE  = 8'h02;
	localparam logic [7:0] DTM_RST_HI    = 8'h7F;
	localparam logic [7:0] DTM_RST_LO    = 8'hC9;
	localparam logic [7:0] DTM_RST_PTR   = 8'h0F;
	localparam logic [7:0] DTM_INVALID   = 8'hFF;
	localparam logic [7:0] DTM_CFG_WMASK = 8'hC0;
	localparam logic [7:0] DTM_RATE_MASK = 8'h07;
	localparam logic [7:0] DTM_TEMP_MIN  = 8'h00;
	localparam logic [1:0] DTM_ST_RSVD   = 2'h0;
	localparam logic [3:0] DTM_BYTE_BITS = 4'h8;
	localparam int         DTM_CFG_MASK  = 7;
	localparam int         DTM_CFG_HALT  = 6;
	localparam int         DTM_F_LHI     = 4;
	localparam int         DTM_F_LLO     = 3;
	localparam int         DTM_F_RHI     = 2;
	localparam int         DTM_F_RLO     = 1;
	localparam int         DTM_F_OPEN    = 0;
	localparam int         DTM_AVG_LOG2  = 4;
	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DTM_SEQ_IDLE   = 2'b00,
		DTM_SEQ_LOCAL  = 2'b01,
		DTM_SEQ_REMOTE = 2'b10
	} dtm_seq_e;
	typedef enum logic [2:0] {
		DTM_BUS_IDLE  = 3'b000,
		DTM_BUS_ADDR  = 3'b001,
		DTM_BUS_AACK  = 3'b010,
		DTM_BUS_WR    = 3'b011,
		DTM_BUS_WACK  = 3'b100,
		DTM_BUS_RD    = 3'b101,
		DTM_BUS_RACK  = 3'b110
	} dtm_bus_e;
endpackage

// >>> dual_channel_temp_monitor_tb.sv
// self-checking bench for the temperature monitor core
// assumes dtm_host as smbus master and a constant-code front end
`timescale 1ns/1ps
`default_nettype none
module dual_channel_temp_monitor_tb;
	import dtm_pkg::*;
	localparam logic [7:0] REV = 8'h9E; // arbitrary value
	logic       ref_clk = 1'b0;
	logic       adc_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       standby_select_n = 1'b0;
	logic       adc_vld = 1'b0;
	wire logic [7:0] adc_code;
	logic [7:0] loc_code = 8'h19;
	logic [7:0] rem_code = 8'hF0;
	logic       scl, host_low, sda_o, sda_oe, alert_n, alert_oe, adc_run, adc_sel;
	wire logic  sda;
	int         bad_count = 0;
	int         num_checks = 0;
	assign sda = !(host_low | sda_oe);
	initial forever #2.5 ref_clk = !ref_clk;
	initial
	begin
		#13;
		forever #40 adc_clk = !adc_clk;
	end
	dtm_core #(.REV_ID(REV)) dut (.ref_clk(ref_clk), .adc_clk(adc_clk), .sys_rst(sys_rst),
		.smb_scl_i(scl), .smb_sda_i(sda), .smb_sda_o(sda_o), .smb_sda_oe(sda_oe),
		.alert_n_o(alert_n), .alert_oe(alert_oe), .standby_select_n(standby_select_n),
		.adc_vld(adc_vld), .adc_code(adc_code), .adc_open(1'b0), .adc_run(adc_run),
		.adc_sel_remote(adc_sel));
	dtm_host h (.scl(scl), .sda_low(host_low), .sda(sda));
	// ----------------------------------------------------------------
	// front end: a sample every other link cycle while running
	// ----------------------------------------------------------------
	// code follows the selection the link tags it with, so no
	// sample straddles a channel switch
	assign adc_code = adc_sel ? rem_code : loc_code;
	always @(posedge adc_clk)
		adc_vld <= adc_run & !adc_vld;
	// ----------------------------------------------------------------
	// checking tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		h.set_ptr(a);
		h.rd(v);
		chk(v & m, e);
	endtask
	// conversions take a while, so poll with a bounded count
	task automatic poll(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		v = ~e;
		for (int n = 0; n < 40 && v !== e; n++)
		begin
			h.set_ptr(a);
			h.rd(v);
		end
		chk(v, e);
		if (v !== e)
			results();
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#400us;
		bad_count++;
		results();
	end
	// ----------------------------------------------------------------
	// main sequence: power up in standby, then run
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge adc_clk);
		@(posedge ref_clk) sys_rst <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk({5'h00, sda_o, alert_n, alert_oe}, 8'h01);
		rr(DTM_RA_LOCAL, 8'hFF, 8'h80);
		rr(DTM_RA_REMOTE, 8'hFF, 8'h80);
		rr(DTM_RA_STATUS, 8'hFF, 8'h28);
		rr(DTM_RA_LLO, 8'hFF, 8'hC9);
		rr(DTM_RA_REV, 8'hF0, REV & 8'hF0);
		rr(DTM_WA_LHI, 8'hFF, DTM_INVALID);
		h.wr(DTM_RA_LHI, 8'h00);
		rr(DTM_RA_LHI, 8'hFF, 8'h7F);
		h.wr(DTM_WA_LLO, 8'h80);
		h.wr(DTM_WA_RLO, 8'h80);
		rr(DTM_RA_STATUS, 8'hFF, 8'h28);
		rr(DTM_RA_STATUS, 8'hFF, 8'h00);
		chk({5'h00, sda_o, alert_n, alert_oe}, 8'h02);
		@(posedge ref_clk) standby_select_n <= 1'b1;
		poll(DTM_RA_LOCAL, 8'h19);
		poll(DTM_RA_REMOTE, 8'h00);
		h.wr(DTM_WA_LHI, 8'h19);
		rr(DTM_RA_STATUS, 8'h7C, 8'h00);
		h.wr(DTM_WA_LHI, 8'h18);
		rr(DTM_RA_STATUS, 8'h7C, 8'h40);
		chk({5'h00, sda_o, alert_n, alert_oe}, 8'h01);
		h.wr(DTM_WA_CFG, 8'h80);
		chk({5'h00, sda_o, alert_n, alert_oe}, 8'h02);
		h.wr(DTM_WA_CFG, 8'hC0);
		rr(DTM_RA_CFG, 8'hFF, 8'hC0);
		@(posedge adc_clk) loc_code <= 8'h32;
		repeat (4000) @(posedge ref_clk);
		rr(DTM_RA_LOCAL, 8'hFF, 8'h19);
		h.wr(DTM_WA_ONESHOT, 8'h00);
		poll(DTM_RA_LOCAL, 8'h32);
		results();
	end
endmodule
`default_nettype wire
